/* inc/duhp_pkg.sv */
// Shared constants and types for the dual UART host bus port
package duhp_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 8;
  localparam int MCR_IDX = 3'h4;
  localparam int MCR_GP_BIT = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] MCR_ADDR = 3'h4;
  localparam logic [2:0] HOLD_ADDR = 3'h0;
  localparam int STROBE_CYCLES = 2;
  typedef logic [ADDR_W-1:0] duhp_addr_t;
  typedef logic [DATA_W-1:0] duhp_data_t;
  typedef enum logic [1:0] {DUHP_RD, DUHP_WR} duhp_kind_e;
endpackage : duhp_pkg

/* inc/duhp_if.sv */
// Pin-level bus between host and dual UART port
`timescale 1ns/1ps
interface duhp_if;
  import duhp_pkg::*;
  logic [2:0] register_select_lines;
  logic [7:0] host_data_out;
  logic [7:0] host_data_oe_n;
  logic [7:0] dev_data_out;
  logic [7:0] dev_data_oe_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan_first_select_n;
  logic chan_second_select_n;
  logic [7:0] data_bus;
  assign data_bus = (~dev_data_oe_n & dev_data_out) | (~host_data_oe_n & host_data_out);
  modport device (
    input register_select_lines, read_strobe_n, write_strobe_n,
    input chan_first_select_n, chan_second_select_n, data_bus,
    output dev_data_out, dev_data_oe_n
  );
  modport host (
    output register_select_lines, read_strobe_n, write_strobe_n,
    output chan_first_select_n, chan_second_select_n, host_data_out, host_data_oe_n,
    input data_bus
  );
endinterface : duhp_if

/* rtl/duhp_host.sv */
// Host end: runs one strobed register read or write per request
`timescale 1ns/1ps
module duhp_host
  import duhp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // User request
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic req_chan_in,
  input wire duhp_pkg::duhp_addr_t req_addr_in,
  input wire duhp_pkg::duhp_data_t req_data_in,
  // User answer
  output logic busy_out,
  output logic done_out,
  output duhp_pkg::duhp_data_t rd_data_out,
  // Bus
  duhp_if.host bus
);
  import duhp_pkg::*;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_END} duhp_hst_e;
  duhp_hst_e state;
  logic wr;
  logic chan;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [1:0] cnt;
  logic [7:0] rdata;
  logic done;
  wire in_strobe = (state == H_STROBE);
  wire sel = (state != H_IDLE);
  assign bus.register_select_lines = addr;
  assign bus.chan_first_select_n = ~(sel && !chan);
  assign bus.chan_second_select_n = ~(sel && chan);
  assign bus.read_strobe_n = ~(in_strobe && !wr);
  assign bus.write_strobe_n = ~(in_strobe && wr);
  assign bus.host_data_out = wdata;
  assign bus.host_data_oe_n = {8{~(sel && wr)}};
  assign busy_out = sel;
  assign done_out = done;
  assign rd_data_out = rdata;
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= H_IDLE;
      wr <= 1'b0;
      chan <= 1'b0;
      addr <= 3'h0;
      wdata <= 8'h00;
      cnt <= 2'h0;
      rdata <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        H_IDLE:
        begin
          if (req_in)
          begin
            wr <= req_write_in;
            chan <= req_chan_in;
            addr <= req_addr_in;
            wdata <= req_data_in;
            state <= H_SETUP;
          end
        end
        H_SETUP:
        begin
          cnt <= 2'(STROBE_CYCLES - 1);
          state <= H_STROBE;
        end
        H_STROBE:
        begin
          if (cnt == 2'h0)
          begin
            // Capture at the strobe's rising edge
            if (!wr)
              rdata <= bus.data_bus;
            state <= H_END;
          end
          else
            cnt <= cnt - 2'h1;
        end
        H_END:
        begin
          done <= 1'b1;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : duhp_host

/* rtl/duhp_device.sv */
// Device end: strobe-timed register port of two UART channels
// Operation
// - Three address lines pick one register
// - Eight-bit bidirectional data, device drives on reads
// - Read strobe fall fetches byte onto bus
// - Read byte held until strobe rises
// - Write byte latched on write strobe rise
// - First channel answers only when selected
// - Second channel answers only when selected
// - First channel control bit 3 drives irq, gp
// - Second channel control bit 3 likewise
// - First channel transmit ready, active low
// - First channel receive ready, active low
// - Second channel transmit ready, active low
// - Second channel receive ready, active low
`timescale 1ns/1ps
module duhp_device
  import duhp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Bus
  duhp_if.device bus,
  // Channel core status and events
  input wire logic [1:0] irq_req_in,
  input wire logic [1:0] rx_byte_in_valid_in,
  input wire duhp_pkg::duhp_data_t rx_byte_in,
  input wire logic [1:0] tx_taken_in,
  // Channel pins
  output logic chan_first_irq_out,
  output logic chan_first_irq_oe_n_out,
  output logic chan_second_irq_out,
  output logic chan_second_irq_oe_n_out,
  output logic chan_first_gp_out_n_out,
  output logic chan_second_gp_out_n_out,
  output logic chan_first_tx_ready_n_out,
  output logic chan_first_rx_ready_n_out,
  output logic chan_second_tx_ready_n_out,
  output logic chan_second_rx_ready_n_out,
  // Register write events towards the channel cores
  output logic [1:0] tx_load_out,
  output duhp_pkg::duhp_data_t tx_data_out
);
  import duhp_pkg::*;
  logic [7:0] regs [2][NUM_REGS];
  logic [7:0] rx_hold [2];
  logic [1:0] rx_empty;
  logic [2:0] rd_addr;
  logic [1:0] tx_full;
  logic rd_q;
  logic wr_q;
  logic [7:0] rd_byte;
  logic rd_active;
  logic [7:0] wr_byte;
  logic [2:0] wr_addr;
  logic wr_chan;
  logic wr_sel;
  logic rd_chan;
  logic [1:0] tx_load;
  logic [1:0] irq_q;
  logic [1:0] irq_oe_n;
  logic [1:0] gp_n;
  wire sel_a = !bus.chan_first_select_n;
  wire sel_b = !bus.chan_second_select_n && !sel_a;
  wire any_sel = sel_a || sel_b;
  wire cur_chan = sel_b;
  wire rd_now = any_sel && !bus.read_strobe_n;
  wire wr_now = any_sel && !bus.write_strobe_n;
  wire rd_fall = rd_now && !rd_q;
  wire rd_rise = rd_q && bus.read_strobe_n;
  wire wr_rise = wr_q && bus.write_strobe_n;
  wire [2:0] addr = bus.register_select_lines;
  wire [7:0] fetch = (addr == HOLD_ADDR) ? rx_hold[cur_chan] : regs[cur_chan][addr];
  assign bus.dev_data_out = rd_byte;
  assign bus.dev_data_oe_n = {8{~rd_active}};
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      rd_byte <= 8'h00;
      rd_active <= 1'b0;
      rd_chan <= 1'b0;
      rd_addr <= 3'h0;
      wr_byte <= 8'h00;
      wr_addr <= 3'h0;
      wr_chan <= 1'b0;
      wr_sel <= 1'b0;
    end
    else
    begin
      rd_q <= rd_now;
      wr_q <= wr_now;
      if (rd_fall)
      begin
        rd_byte <= fetch;
        rd_chan <= cur_chan;
        rd_addr <= addr;
        rd_active <= 1'b1;
      end
      else if (!rd_now)
        rd_active <= 1'b0;
      if (wr_now)
      begin
        wr_byte <= bus.data_bus;
        wr_addr <= addr;
        wr_chan <= cur_chan;
        wr_sel <= 1'b1;
      end
      else
        wr_sel <= 1'b0;
    end
  end
  // Register file and holding flags per channel
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int c = 0; c < 2; c++)
      begin
        for (int r = 0; r < NUM_REGS; r++)
          regs[c][r] <= REG_RESET;
        rx_hold[c] <= REG_RESET;
      end
      rx_empty <= 2'b11;
      tx_full <= 2'b00;
      tx_load <= 2'b00;
      tx_data_out <= 8'h00;
    end
    else
    begin
      tx_load <= 2'b00;
      for (int c = 0; c < 2; c++)
      begin
        // Write on strobe rise, strobe stays inside the select
        if (wr_rise && wr_sel && wr_chan == c[0])
        begin
          regs[c][wr_addr] <= wr_byte;
          if (wr_addr == HOLD_ADDR)
          begin
            tx_load[c] <= 1'b1;
            tx_data_out <= wr_byte;
          end
        end
        // New byte wins over a read that empties the holding register
        if (rx_byte_in_valid_in[c])
        begin
          rx_hold[c] <= rx_byte_in;
          rx_empty[c] <= 1'b0;
        end
        // Only a completed read of the holding register empties it
        else if (rd_rise && rd_active && rd_chan == c[0] && rd_addr == HOLD_ADDR)
          rx_empty[c] <= 1'b1;
        if (wr_rise && wr_sel && wr_chan == c[0] && wr_addr == HOLD_ADDR)
          tx_full[c] <= 1'b1;
        else if (tx_taken_in[c])
          tx_full[c] <= 1'b0;
      end
    end
  end
  assign tx_load_out = tx_load;
  // Interrupt drive and general purpose pin from control bit 3
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      irq_q <= 2'b00;
      irq_oe_n <= 2'b11;
      gp_n <= 2'b11;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        irq_q[c] <= irq_req_in[c];
        irq_oe_n[c] <= ~regs[c][MCR_ADDR][MCR_GP_BIT];
        gp_n[c] <= ~regs[c][MCR_ADDR][MCR_GP_BIT];
      end
    end
  end
  assign chan_first_irq_out = irq_q[0];
  assign chan_second_irq_out = irq_q[1];
  assign chan_first_irq_oe_n_out = irq_oe_n[0];
  assign chan_second_irq_oe_n_out = irq_oe_n[1];
  assign chan_first_gp_out_n_out = gp_n[0];
  assign chan_second_gp_out_n_out = gp_n[1];
  // Ready outputs low while holding register can accept or holds data
  assign chan_first_tx_ready_n_out = tx_full[0];
  assign chan_first_rx_ready_n_out = rx_empty[0];
  assign chan_second_tx_ready_n_out = tx_full[1];
  assign chan_second_rx_ready_n_out = rx_empty[1];
endmodule : duhp_device

/* dv/duhp_props.sv */
// Bus assertions watching the joined host and device ends
`timescale 1ns/1ps
module duhp_props (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Bus signals
  input wire logic [2:0] register_select_lines,
  input wire logic [7:0] host_data_oe_n,
  input wire logic [7:0] dev_data_out,
  input wire logic [7:0] dev_data_oe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_first_select_n,
  input wire logic chan_second_select_n
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic sel = !chan_first_select_n || !chan_second_select_n;
  wire logic stb = !read_strobe_n || !write_strobe_n;
  wire logic rd = sel && !read_strobe_n;
  property p_idle_float; !sel && $past(!sel) |-> &dev_data_oe_n; endproperty
  a_idle_float: assert property (p_idle_float) else $error("device drives while idle");
  property p_rd_drive; rd ##1 rd |-> dev_data_oe_n == 8'h00; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read byte not driven");
  property p_rd_hold; rd ##1 rd ##1 read_strobe_n |-> dev_data_oe_n == 8'h00 && $stable(dev_data_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte lost before strobe end");
  property p_wr_quiet; !write_strobe_n |-> &dev_data_oe_n; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drives during write");
  property p_wr_host; !write_strobe_n |-> host_data_oe_n == 8'h00; endproperty
  a_wr_host: assert property (p_wr_host) else $error("host not driving write data");
  property p_rd_host; !read_strobe_n |-> &host_data_oe_n; endproperty
  a_rd_host: assert property (p_rd_host) else $error("host drives during read");
  property p_stb_sel; stb |-> sel; endproperty
  a_stb_sel: assert property (p_stb_sel) else $error("strobe outside select");
  property p_one_sel; sel |-> chan_first_select_n != chan_second_select_n; endproperty
  a_one_sel: assert property (p_one_sel) else $error("both channels selected");
  property p_addr_hold; stb && $past(stb) |-> $stable(register_select_lines); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
  c_rd: cover property (rd ##1 rd);
  c_wr_second: cover property (!write_strobe_n && !chan_second_select_n);
  c_rd_second: cover property (!read_strobe_n && !chan_second_select_n);
endmodule : duhp_props

/* dv/dual_uart_host_bus_port_tb.sv */
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
module dual_uart_host_bus_port_tb;
  import duhp_pkg::*;
  logic sys_clk_in = 0;
  logic rstn_in = 0;
  logic req_in = 0;
  logic req_write_in = 0;
  logic req_chan_in = 0;
  duhp_addr_t req_addr_in = '0;
  duhp_data_t req_data_in = '0;
  duhp_data_t rx_byte_in = '0;
  duhp_data_t rd_data, tx_data;
  logic [1:0] irq_req_in = '0;
  logic [1:0] rx_v = '0;
  logic [1:0] tx_taken_in = '0;
  logic [1:0] tx_load, irq, irq_oe_n, gp_n, txr_n, rxr_n;
  logic [1:0] seen_load = '0;
  logic busy, done;
  int bad_count = 0;
  int n_compared = 0;
  duhp_if bus();
  duhp_host i_duhp_host (.sys_clk_in, .rstn_in, .req_in, .req_write_in, .req_chan_in, .req_addr_in,
    .req_data_in, .busy_out(busy), .done_out(done), .rd_data_out(rd_data), .bus(bus));
  duhp_device i_duhp_device (.sys_clk_in, .rstn_in, .bus(bus), .irq_req_in, .rx_byte_in_valid_in(rx_v),
    .rx_byte_in, .tx_taken_in, .chan_first_irq_out(irq[0]), .chan_first_irq_oe_n_out(irq_oe_n[0]),
    .chan_second_irq_out(irq[1]), .chan_second_irq_oe_n_out(irq_oe_n[1]), .chan_first_gp_out_n_out(gp_n[0]),
    .chan_second_gp_out_n_out(gp_n[1]), .chan_first_tx_ready_n_out(txr_n[0]),
    .chan_first_rx_ready_n_out(rxr_n[0]), .chan_second_tx_ready_n_out(txr_n[1]),
    .chan_second_rx_ready_n_out(rxr_n[1]), .tx_load_out(tx_load), .tx_data_out(tx_data));
  duhp_props i_duhp_props (.sys_clk_in, .rstn_in, .register_select_lines(bus.register_select_lines),
    .host_data_oe_n(bus.host_data_oe_n), .dev_data_out(bus.dev_data_out), .dev_data_oe_n(bus.dev_data_oe_n),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .chan_first_select_n(bus.chan_first_select_n), .chan_second_select_n(bus.chan_second_select_n));
  initial forever #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (tx_load != 2'b00) seen_load <= tx_load;
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic ch, input duhp_addr_t a, input duhp_data_t d);
    int n;
    @(negedge sys_clk_in);
    req_in = 1;
    req_write_in = wr;
    req_chan_in = ch;
    req_addr_in = a;
    req_data_in = d;
    @(negedge sys_clk_in);
    req_in = 0;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n == 20)
    begin
      bad_count++;
      $display("[FAIL] %0t transfer hung", $time);
      final_report();
    end
  endtask : xfer
  task automatic rd(input logic ch, input duhp_addr_t a, input duhp_data_t exp);
    xfer(1'b0, ch, a, 8'h00);
    chk(rd_data, exp, "read data");
  endtask : rd
  task automatic settle;
    repeat (2) @(negedge sys_clk_in);
  endtask : settle
  initial
  begin
    repeat (6) @(negedge sys_clk_in);
    rstn_in = 1;
    chk({gp_n, irq_oe_n, txr_n, rxr_n}, 8'hf3, "reset pins");
    for (int ch = 0; ch < 2; ch++)
    begin
      xfer(1'b1, ch[0], MCR_ADDR, {7'h04, ch[0]});
      settle();
      chk({4'h0, gp_n, irq_oe_n}, ch ? 8'h00 : 8'h0a, "control pins");
    end
    irq_req_in = 2'b01;
    settle();
    chk({6'h00, irq}, 8'h01, "irq level");
    irq_req_in = 2'b10;
    settle();
    chk({6'h00, irq}, 8'h02, "second irq level");
    rd(1'b0, MCR_ADDR, 8'h08);
    rd(1'b1, MCR_ADDR, 8'h09);
    for (int ch = 0; ch < 2; ch++)
    begin
      xfer(1'b1, ch[0], HOLD_ADDR, 8'h5a ^ 8'(ch));
      settle();
      chk(tx_data, 8'h5a ^ 8'(ch), "tx byte");
      chk({seen_load, txr_n}, {2'(1 << ch), 2'(1 << ch)}, "tx load");
      tx_taken_in = 2'(1 << ch);
      @(negedge sys_clk_in);
      tx_taken_in = 2'b00;
      settle();
      chk({6'h00, txr_n}, 8'h00, "tx ready");
      rx_byte_in = 8'hc3 ^ 8'(ch);
      rx_v = 2'(1 << ch);
      @(negedge sys_clk_in);
      rx_v = 2'b00;
      settle();
      chk({6'h00, rxr_n}, {6'h00, ~2'(1 << ch)}, "rx ready");
      rd(ch[0], HOLD_ADDR, 8'hc3 ^ 8'(ch));
      settle();
      chk({6'h00, rxr_n}, 8'h03, "rx cleared");
    end
    // Mid-run reset returns pins and control bits to defaults
    rstn_in = 0;
    @(negedge sys_clk_in);
    rstn_in = 1;
    settle();
    chk({gp_n, irq_oe_n, txr_n, rxr_n}, 8'hf3, "pins after reset");
    rd(1'b1, MCR_ADDR, 8'h00);
    final_report();
  end
endmodule : dual_uart_host_bus_port_tb
